// ==== logic/rcb_pkg.sv ====
// receiver configuration register bank: shared constants and types
package rcb_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] RCB_IDX_BANDPASS_PA = 8'h11;
  localparam logic [7:0] RCB_IDX_RECOVERY_PATTERN = 8'h12;
  localparam logic [7:0] RCB_IDX_REF_DIVIDER = 8'h13;
  localparam logic [7:0] RCB_IDX_SIGNAL_STRENGTH = 8'h14;
  localparam logic [7:0] RCB_IDX_OOK_DETECTOR = 8'h15;
  localparam logic [7:0] RCB_IDX_PATTERN_MSB = 8'h16;

  // reset values
  localparam logic [7:0] RCB_RST_BANDPASS_PA = 8'h38;
  localparam logic [7:0] RCB_RST_RECOVERY_PATTERN = 8'h18;
  localparam logic [7:0] RCB_RST_REF_DIVIDER = 8'h07;
  localparam logic [7:0] RCB_RST_SIGNAL_STRENGTH = 8'h00;
  localparam logic [7:0] RCB_RST_OOK_DETECTOR = 8'h00;

  // field positions
  localparam int RCB_CENTER_MSB = 7;
  localparam int RCB_CENTER_LSB = 4;
  localparam int RCB_AMP_STEP_BIT = 3;
  localparam int RCB_BANDPASS_EN_BIT = 7;
  localparam int RCB_RECOVERY_DIS_BIT = 6;
  localparam int RCB_RECOG_EN_BIT = 5;
  localparam int RCB_SIZE_MSB = 4;
  localparam int RCB_SIZE_LSB = 3;
  localparam int RCB_TOL_MSB = 2;
  localparam int RCB_TOL_LSB = 1;
  localparam int RCB_STEP_MSB = 7;
  localparam int RCB_STEP_LSB = 5;
  localparam int RCB_INTERVAL_MSB = 4;
  localparam int RCB_INTERVAL_LSB = 2;
  localparam int RCB_COEFF_MSB = 1;
  localparam int RCB_COEFF_LSB = 0;

  // writable bit masks; unused bits read as zero
  localparam logic [7:0] RCB_MASK_BANDPASS_PA = 8'hF8;
  localparam logic [7:0] RCB_MASK_RECOVERY_PATTERN = 8'hFE;

  localparam int RCB_BYTE_BITS = 8;
  localparam int RCB_PATTERN_BITS = 32;
  localparam logic [5:0] RCB_FILL_MAX = 6'h20;

  // start-pattern bytes, msb is received first
  typedef struct packed {
    logic [7:0] msb;
    logic [7:0] second;
    logic [7:0] third;
    logic [7:0] lsb;
  } rcb_pattern_t;

  // decoded configuration driven to the receiver
  typedef struct packed {
    logic [3:0] bandpass_center;
    logic [4:0] bandpass_center_mult;
    logic amp_step_regulation;
    logic bandpass_enable;
    logic recovery_enable;
    logic pattern_detect_enable;
    logic [1:0] pattern_size;
    logic [1:0] pattern_tolerance;
    logic [7:0] reference_divider_value;
    logic [3:0] peak_decay_half_db;
    logic [2:0] peak_update_interval;
    logic peak_update_slow;
    logic [2:0] peak_update_shift;
    logic [1:0] average_filter_coefficient_select;
    logic average_long;
  } rcb_cfg_t;

endpackage : rcb_pkg

// ==== logic/rcb_ref_divider.sv ====
// reference clock divider: one-cycle tick every divider+1 clocks
`timescale 1ns/1ps
`default_nettype none

module rcb_ref_divider
  import rcb_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] divider_i,
  output logic tick_o
);

  logic [7:0] count;
  logic [7:0] next_count;
  logic next_tick;

  always_comb begin
    next_count = count + 8'h01;
    next_tick = 1'b0;
    if (count >= divider_i) begin
      next_count = 8'h00;
      next_tick = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count <= 8'h00;
      tick_o <= 1'b0;
    end else begin
      count <= next_count;
      tick_o <= next_tick;
    end
  end

endmodule : rcb_ref_divider

`default_nettype wire

// ==== logic/rcb_register_bank.sv ====
// receiver configuration register bank with wishbone slave and pattern detector
//
// Added by the designer: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// R01 - bits 7:4 of first register set band-pass centre multiplier L+1; default 0011
// R02 - bit 3 of first register switches amplifier step regulation on
// R03 - bit 6 of second register set means clock and data recovery off
// R04 - bit 5 enables start-pattern recognition; bit 7 enables band-pass filter
// R05 - pattern size field selects one to four bytes, msb byte first
// R06 - tolerance field accepts zero to three mismatched pattern bits
// R07 - divider value F makes a reference tick every F+1 clocks; reset 0x07
// R08 - peak decay step codes give 0.5 to 2.0 dB, then 3 to 6 dB
// R09 - update codes give once per 1,2,4,8 chips, then 2,4,8,16 per chip
// R10 - low codes select short averaging, high codes long averaging
// R11 - most significant pattern byte is matched first
// R12 - signal strength register is read-only, shows latest level
module rcb_register_bank
  import rcb_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [9:0] adr_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  input wire logic we_i,
  input wire logic [3:0] sel_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  output logic ack_o,
  input wire logic [7:0] rssi_i,
  input wire logic rssi_valid_i,
  input wire logic rx_bit_i,
  input wire logic rx_bit_valid_i,
  input wire rcb_pattern_t pattern_i,
  output rcb_cfg_t cfg_o,
  output logic ref_tick_o,
  output logic pattern_found_o
);

  // ----------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------
  function automatic logic [9:0] byte_addr(input logic [7:0] idx);
    byte_addr = {idx, 2'b00};
  endfunction : byte_addr

  function automatic logic [5:0] popcount(input logic [31:0] v);
    logic [5:0] n;
    n = 6'h00;
    for (int i = 0; i < RCB_PATTERN_BITS; i++) begin
      n = n + {5'h00, v[i]};
    end
    popcount = n;
  endfunction : popcount

  function automatic logic [3:0] decay_half_db(input logic [2:0] code);
    if (code[2]) begin
      decay_half_db = {1'b0, code[1:0], 1'b0} + 4'h6;
    end else begin
      decay_half_db = {2'b00, code[1:0]} + 4'h1;
    end
  endfunction : decay_half_db

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic [7:0] rx_bandpass_center_amp_step_regulation;
  logic [7:0] rx_recovery_pattern_control;
  logic [7:0] reference_clock_divider;
  logic [7:0] signal_strength_result;
  logic [7:0] ook_detector_control;
  logic [7:0] next_bandpass_pa;
  logic [7:0] next_recovery_pattern;
  logic [7:0] next_ref_divider;
  logic [7:0] next_signal_strength;
  logic [7:0] next_ook_detector;
  logic [31:0] next_dat;
  logic next_ack;
  logic wr_en;
  logic [7:0] rd_byte;

  always_comb begin
    next_bandpass_pa = rx_bandpass_center_amp_step_regulation;
    next_recovery_pattern = rx_recovery_pattern_control;
    next_ref_divider = reference_clock_divider;
    next_ook_detector = ook_detector_control;
    next_signal_strength = signal_strength_result;
    // answer one cycle after the request, drop ack in between
    next_ack = cyc_i && stb_i && !ack_o;
    wr_en = next_ack && we_i && sel_i[0];
    rd_byte = 8'h00;
    unique case (adr_i)
      byte_addr(RCB_IDX_BANDPASS_PA): begin
        rd_byte = rx_bandpass_center_amp_step_regulation;
        if (wr_en) begin
          next_bandpass_pa = dat_i[7:0] & RCB_MASK_BANDPASS_PA; // R01 R02
        end
      end
      byte_addr(RCB_IDX_RECOVERY_PATTERN): begin
        rd_byte = rx_recovery_pattern_control;
        if (wr_en) begin
          next_recovery_pattern = dat_i[7:0] & RCB_MASK_RECOVERY_PATTERN; // R03 R04
        end
      end
      byte_addr(RCB_IDX_REF_DIVIDER): begin
        rd_byte = reference_clock_divider;
        if (wr_en) begin
          next_ref_divider = dat_i[7:0]; // R07
        end
      end
      byte_addr(RCB_IDX_SIGNAL_STRENGTH): begin
        rd_byte = signal_strength_result; // R12
      end
      byte_addr(RCB_IDX_OOK_DETECTOR): begin
        rd_byte = ook_detector_control;
        if (wr_en) begin
          next_ook_detector = dat_i[7:0]; // R08 R09 R10
        end
      end
      default: begin
        rd_byte = 8'h00;
      end
    endcase
    // host writes never reach the measured level
    if (rssi_valid_i) begin
      next_signal_strength = rssi_i; // R12
    end
    next_dat = dat_o;
    if (next_ack) begin
      next_dat = {24'h000000, rd_byte};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_bandpass_center_amp_step_regulation <= RCB_RST_BANDPASS_PA;
      rx_recovery_pattern_control <= RCB_RST_RECOVERY_PATTERN;
      reference_clock_divider <= RCB_RST_REF_DIVIDER;
      signal_strength_result <= RCB_RST_SIGNAL_STRENGTH;
      ook_detector_control <= RCB_RST_OOK_DETECTOR;
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
    end else begin
      rx_bandpass_center_amp_step_regulation <= next_bandpass_pa;
      rx_recovery_pattern_control <= next_recovery_pattern;
      reference_clock_divider <= next_ref_divider;
      signal_strength_result <= next_signal_strength;
      ook_detector_control <= next_ook_detector;
      ack_o <= next_ack;
      dat_o <= next_dat;
    end
  end

  // ----------------------------------------------------------------
  // decoded configuration
  // ----------------------------------------------------------------
  rcb_cfg_t next_cfg;
  logic [2:0] interval_code;

  always_comb begin
    interval_code = ook_detector_control[RCB_INTERVAL_MSB:RCB_INTERVAL_LSB];
    next_cfg.bandpass_center = rx_bandpass_center_amp_step_regulation[RCB_CENTER_MSB:RCB_CENTER_LSB]; // R01
    next_cfg.bandpass_center_mult = {1'b0, next_cfg.bandpass_center} + 5'h01; // R01
    next_cfg.amp_step_regulation = rx_bandpass_center_amp_step_regulation[RCB_AMP_STEP_BIT]; // R02
    next_cfg.bandpass_enable = rx_recovery_pattern_control[RCB_BANDPASS_EN_BIT]; // R04
    next_cfg.recovery_enable = !rx_recovery_pattern_control[RCB_RECOVERY_DIS_BIT]; // R03
    next_cfg.pattern_detect_enable = rx_recovery_pattern_control[RCB_RECOG_EN_BIT]; // R04
    next_cfg.pattern_size = rx_recovery_pattern_control[RCB_SIZE_MSB:RCB_SIZE_LSB]; // R05
    next_cfg.pattern_tolerance = rx_recovery_pattern_control[RCB_TOL_MSB:RCB_TOL_LSB]; // R06
    next_cfg.reference_divider_value = reference_clock_divider; // R07
    next_cfg.peak_decay_half_db =
      decay_half_db(ook_detector_control[RCB_STEP_MSB:RCB_STEP_LSB]); // R08
    next_cfg.peak_update_interval = interval_code; // R09
    next_cfg.peak_update_slow = !interval_code[2]; // R09
    // slow: once per 2^shift chips; fast: 2^shift updates per chip
    next_cfg.peak_update_shift = interval_code[2] ?
      ({1'b0, interval_code[1:0]} + 3'h1) : {1'b0, interval_code[1:0]}; // R09
    next_cfg.average_filter_coefficient_select =
      ook_detector_control[RCB_COEFF_MSB:RCB_COEFF_LSB]; // R10
    next_cfg.average_long = ook_detector_control[RCB_COEFF_MSB]; // R10
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_o <= '0;
    end else begin
      cfg_o <= next_cfg;
    end
  end

  // ----------------------------------------------------------------
  // reference clock divider
  // ----------------------------------------------------------------
  rcb_ref_divider u_ref_divider (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .divider_i(reference_clock_divider),
    .tick_o(ref_tick_o)
  ); // R07

  // ----------------------------------------------------------------
  // start-pattern detector
  // ----------------------------------------------------------------
  logic [31:0] shift_bits;
  logic [31:0] next_shift_bits;
  logic [5:0] fill;
  logic [5:0] next_fill;
  logic next_found;
  logic [31:0] expected;
  logic [31:0] window_mask;
  logic [5:0] pattern_len;
  logic [5:0] errors;
  logic [1:0] size_code;

  always_comb begin
    size_code = rx_recovery_pattern_control[RCB_SIZE_MSB:RCB_SIZE_LSB];
    pattern_len = {2'b00, size_code, 2'b00} + {2'b00, size_code, 2'b00}
      + 6'(RCB_BYTE_BITS); // R05
    // msb byte sits highest, so it is the oldest bit of the window
    expected = pattern_i >> (6'(RCB_PATTERN_BITS) - pattern_len); // R05 R11
    window_mask = ~(32'hFFFFFFFF << pattern_len);
    next_shift_bits = shift_bits;
    next_fill = fill;
    next_found = 1'b0;
    errors = 6'h00;
    if (rx_bit_valid_i && !rx_recovery_pattern_control[RCB_RECOVERY_DIS_BIT]) begin // R03
      next_shift_bits = {shift_bits[30:0], rx_bit_i};
      if (fill != RCB_FILL_MAX) begin
        next_fill = fill + 6'h01;
      end
    end
    errors = popcount((next_shift_bits ^ expected) & window_mask); // R06
    if (rx_recovery_pattern_control[RCB_RECOG_EN_BIT] && rx_bit_valid_i
        && !rx_recovery_pattern_control[RCB_RECOVERY_DIS_BIT]
        && next_fill >= pattern_len
        && errors <= {4'h0, rx_recovery_pattern_control[RCB_TOL_MSB:RCB_TOL_LSB]}) begin
      next_found = 1'b1; // R04 R06
    end
    if (!rx_recovery_pattern_control[RCB_RECOG_EN_BIT]) begin
      next_fill = 6'h00; // R04
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      shift_bits <= 32'h00000000;
      fill <= 6'h00;
      pattern_found_o <= 1'b0;
    end else begin
      shift_bits <= next_shift_bits;
      fill <= next_fill;
      pattern_found_o <= next_found;
    end
  end

endmodule : rcb_register_bank

`default_nettype wire

// ==== testbench/rcb_register_bank_chk.sv ====
// checker for the receiver configuration register bank ports
`timescale 1ns/1ps
`default_nettype none

module rcb_register_bank_chk
  import rcb_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [9:0] adr_i,
  input wire logic we_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic [7:0] rssi_i,
  input wire logic rssi_valid_i,
  input wire rcb_cfg_t cfg_o,
  input wire logic ref_tick_o,
  input wire logic pattern_found_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ----------------------------------------
  // helper state
  // ----------------------------------------
  logic rd;
  logic [7:0] level;
  logic [8:0] gap;
  logic moved;
  assign rd = ack_o && !we_i;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      level <= 8'h00;
      gap <= 9'h000;
      moved <= 1'b1;
    end else begin
      level <= rssi_valid_i ? rssi_i : level;
      gap <= ref_tick_o ? 9'h001 : gap + {8'h00, gap != 9'h1FF};
      moved <= ref_tick_o ? 1'b0 : (moved || (ack_o && we_i && adr_i == 10'h04C));
    end
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  first_reg_a: assert property (rd && adr_i == 10'h044 |->
    dat_o[7:0] == {cfg_o.bandpass_center, cfg_o.amp_step_regulation, 3'b000})
    else $error("first register fields differ from configuration");
  center_mult_a: assert property (!$past(rst_i) |->
    cfg_o.bandpass_center_mult == {1'b0, cfg_o.bandpass_center} + 5'h01)
    else $error("centre multiplier not centre plus one");
  recovery_sense_a: assert property (rd && adr_i == 10'h048 |->
    cfg_o.recovery_enable != dat_o[6]) else $error("recovery enable not inverted");
  pattern_ctrl_a: assert property (rd && adr_i == 10'h048 |->
    {dat_o[7], dat_o[5:0]} == {cfg_o.bandpass_enable, cfg_o.pattern_detect_enable,
    cfg_o.pattern_size, cfg_o.pattern_tolerance, 1'b0}) else $error("pattern control mismatch");
  tick_period_a: assert property (ref_tick_o && !moved |->
    gap == {1'b0, cfg_o.reference_divider_value} + 9'h001) else $error("tick period wrong");
  decay_step_a: assert property (rd && adr_i == 10'h054 |->
    cfg_o.peak_decay_half_db == (dat_o[7] ? {1'b0, dat_o[6:5], 1'b0} + 4'h6
    : {2'b00, dat_o[6:5]} + 4'h1)) else $error("peak decay step wrong");
  rate_avg_a: assert property (rd && adr_i == 10'h054 |->
    cfg_o.peak_update_interval == dat_o[4:2] && cfg_o.peak_update_slow == !dat_o[4]
    && cfg_o.peak_update_shift == {1'b0, dat_o[3:2]} + {2'b00, dat_o[4]}
    && cfg_o.average_filter_coefficient_select == dat_o[1:0]
    && cfg_o.average_long == dat_o[1]) else $error("update rate or averaging wrong");
  strength_ro_a: assert property (rd && adr_i == 10'h050 |->
    dat_o[7:0] == $past(level)) else $error("strength register not latest level");
  cover property (rd && adr_i == 10'h050);
  cover property (ref_tick_o && !moved);
  cover property (pattern_found_o);
endmodule : rcb_register_bank_chk

bind rcb_register_bank rcb_register_bank_chk i_chk (.clk_i(clk_i), .rst_i(rst_i),
  .adr_i(adr_i), .we_i(we_i), .dat_o(dat_o), .ack_o(ack_o), .rssi_i(rssi_i),
  .rssi_valid_i(rssi_valid_i), .cfg_o(cfg_o), .ref_tick_o(ref_tick_o),
  .pattern_found_o(pattern_found_o));

`default_nettype wire

// ==== testbench/rcb_register_bank_test.sv ====
// self-checking bench for the receiver configuration register bank
`timescale 1ns/1ps
`default_nettype none

module rcb_register_bank_test
  import rcb_pkg::*;
;
  logic clk_i, rst_i, we_i, cyc_i, stb_i, rssi_valid_i, rx_bit_i, rx_bit_valid_i;
  logic [9:0] adr_i;
  logic [31:0] dat_i, dat_o;
  logic [3:0] sel_i;
  logic [7:0] rssi_i, q;
  logic ack_o, ref_tick_o, pattern_found_o;
  rcb_pattern_t pattern_i;
  rcb_cfg_t cfg_o;
  int bad_count, comparisons, found, n;
  logic [9:0] adrs [6] = '{10'h044, 10'h048, 10'h04C, 10'h050, 10'h054, 10'h3FC};
  logic [7:0] rsts [6] = '{8'h38, 8'h18, 8'h07, 8'h00, 8'h00, 8'h00};
  logic [7:0] masks [6] = '{8'hF8, 8'hFE, 8'hFF, 8'h00, 8'hFF, 8'h00};
  logic [3:0] decay [8] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h8, 4'hA, 4'hC};
  logic [2:0] shift [8] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h1, 3'h2, 3'h3, 3'h4};
  // pattern control value, bits sent from the stream head, expected matches
  logic [7:0] pcfg [8] = '{8'h2A, 8'h28, 8'h6A, 8'h20, 8'h26, 8'h32, 8'h3A, 8'h38};
  logic [5:0] plen [8] = '{6'h10, 6'h10, 6'h10, 6'h10, 6'h10, 6'h18, 6'h20, 6'h20};
  logic [3:0] pexp [8] = '{4'h1, 4'h0, 4'h0, 4'h1, 4'h5, 4'h1, 4'h1, 4'h0};

  rcb_register_bank i_dut (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i),
    .dat_o(dat_o), .we_i(we_i), .sel_i(sel_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
    .rssi_i(rssi_i), .rssi_valid_i(rssi_valid_i), .rx_bit_i(rx_bit_i),
    .rx_bit_valid_i(rx_bit_valid_i), .pattern_i(pattern_i), .cfg_o(cfg_o),
    .ref_tick_o(ref_tick_o), .pattern_found_o(pattern_found_o));

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) if (pattern_found_o === 1'b1) found = found + 1;
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic [9:0] a, input logic w, input logic [7:0] d,
                     input logic [3:0] s);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    adr_i <= a;
    we_i <= w;
    dat_i <= {24'h000000, d};
    sel_i <= s;
    // no assumed latency; the watchdog ends a hung wait
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    q = dat_o[7:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    @(posedge clk_i);
  endtask : bus
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    bus(a, 1'b1, d, 4'h1);
  endtask : wr
  task automatic rd(input logic [9:0] a, input logic [7:0] exp);
    bus(a, 1'b0, 8'h00, 4'hF);
    chk({24'h0, q}, {24'h0, exp});
  endtask : rd
  task automatic tick_gap;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ref_tick_o !== 1'b1 && n < 300);
  endtask : tick_gap
  task automatic give_verdict;
    if (bad_count == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : give_verdict
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    {we_i, cyc_i, stb_i, rssi_valid_i, rx_bit_i, rx_bit_valid_i} = 6'h00;
    {adr_i, dat_i, sel_i, rssi_i} = '0;
    pattern_i = {8'hA5, 8'h3C, 8'h00, 8'h00};
    rst_i = 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    for (int i = 0; i < 6; i++) rd(adrs[i], rsts[i]);
    chk(32'({cfg_o.bandpass_center_mult, cfg_o.recovery_enable}), 32'h9);
    for (int i = 0; i < 6; i++) begin
      wr(adrs[i], 8'hFF);
      rd(adrs[i], masks[i]);
      bus(adrs[i], 1'b1, 8'h00, 4'hE);
      rd(adrs[i], masks[i]);
    end
    chk(32'({cfg_o.bandpass_center_mult, cfg_o.amp_step_regulation}), 32'h21);
    chk(32'({cfg_o.recovery_enable, cfg_o.bandpass_enable}), 32'h1);
    for (int c = 0; c < 8; c++) begin
      wr(10'h054, {c[2:0], c[2:0], c[1:0]});
      rd(10'h054, {c[2:0], c[2:0], c[1:0]});
      chk(32'(cfg_o.peak_decay_half_db), 32'(decay[c]));
      chk(32'({cfg_o.peak_update_shift, cfg_o.average_long}), 32'({shift[c], c[1]}));
    end
    rssi_i <= 8'h5A;
    rssi_valid_i <= 1'b1;
    @(posedge clk_i);
    rssi_valid_i <= 1'b0;
    rssi_i <= 8'hC3;
    @(posedge clk_i);
    wr(10'h050, 8'hFF);
    rd(10'h050, 8'h5A);
    for (int d = 0; d < 6; d += 5) begin
      wr(10'h04C, 8'(d));
      repeat (3) tick_gap();
      chk(32'(n), 32'(d + 1));
    end
    for (int p = 0; p < 8; p++) begin
      wr(10'h048, 8'h00);
      wr(10'h048, pcfg[p]);
      found = 0;
      // stream head differs from the pattern head in one bit
      for (int b = 31; b >= 32 - int'(plen[p]); b--) begin
        rx_bit_i <= 1'(32'hA53D0000 >> b);
        rx_bit_valid_i <= 1'b1;
        @(posedge clk_i);
        rx_bit_valid_i <= 1'b0;
        @(posedge clk_i);
      end
      repeat (2) @(posedge clk_i);
      chk(32'(found), 32'(pexp[p]));
    end
    // reset in mid-run brings every register back
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    for (int i = 0; i < 6; i++) rd(adrs[i], rsts[i]);
    chk(32'({cfg_o.bandpass_center_mult, cfg_o.recovery_enable}), 32'h9);
    give_verdict();
  end
  initial begin
    repeat (5000) @(posedge clk_i);
    bad_count++;
    give_verdict();
  end
endmodule : rcb_register_bank_test

`default_nettype wire
